//--- rtl/oofd_pkg.sv
package oofd_pkg;

  // Instruction word geometry
  localparam int          INSTR_W      = 16;
  localparam int          PC_W         = 21;
  localparam int          BANK_W       = 4;
  localparam int          RAM_ADDR_W   = 12;
  localparam int          OFS_W        = 7;
  localparam logic [3:0]  SECOND_TAG   = 4'hF;
  localparam logic [20:0] PC_STEP      = 21'h000002;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]  ACCESS_HI_BK = 4'hF;
  localparam logic [3:0]  ACCESS_LO_BK = 4'h0;

  // Reset values
  localparam logic [20:0] TPTR_RST     = 21'h000000;
  localparam logic [7:0]  TLATCH_RST   = 8'h00;

  // Instruction format classes, one-hot
  typedef enum logic [11:0] {
    CL_NOP      = 12'h001,
    CL_BYTE     = 12'h002,
    CL_BIT      = 12'h004,
    CL_LIT      = 12'h008,
    CL_PTR_LOAD = 12'h010,
    CL_MOVE2    = 12'h020,
    CL_INDEXED  = 12'h040,
    CL_CALL     = 12'h080,
    CL_GOTO     = 12'h100,
    CL_RET      = 12'h200,
    CL_REL      = 12'h400,
    CL_TBL      = 12'h800
  } oofd_class_e;

  // Table pointer modes
  typedef enum logic [1:0] {
    TM_KEEP     = 2'h0,
    TM_POST_INC = 2'h1,
    TM_POST_DEC = 2'h2,
    TM_PRE_INC  = 2'h3
  } oofd_tmode_e;

  // Word sequencer, one-hot
  typedef enum logic [1:0] {
    ST_FIRST  = 2'h1,
    ST_SECOND = 2'h2
  } oofd_state_e;

  // Decoded operand fields
  typedef struct packed {
    oofd_class_e cls;
    logic        dest_file;
    logic        use_bank;
    logic [11:0] ram_addr;
    logic [2:0]  bit_num;
    logic [7:0]  bit_mask;
    logic [1:0]  ptr_sel;
    logic [11:0] literal;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic [6:0]  src_ofs;
    logic [6:0]  dst_ofs;
    logic        dst_is_ofs;
    logic        fast_shadow;
    oofd_tmode_e table_pointer_mode;
    logic        tbl_write;
    logic        rel_branch;
    logic [20:0] target;
  } oofd_dec_s;

endpackage : oofd_pkg

//--- rtl/oofd_bank_addr.sv
`timescale 1ns/10ps
`default_nettype none
module oofd_bank_addr
  import oofd_pkg::*;
#(
  parameter logic [7:0] SPLIT = ACCESS_SPLIT
) (
  input  wire logic [7:0]        file_addr,       // 8-bit file operand
  input  wire logic              access_bit,      // RAM access operand bit
  input  wire logic [BANK_W-1:0] bank_select_reg, // Current bank number
  output logic [RAM_ADDR_W-1:0]  ram_addr         // Full data address
);

  // Access RAM folds addresses below 0x60 into bank 0 and the rest into bank F; else bank select
  always_comb begin
    if (!access_bit) begin
      ram_addr = (file_addr < SPLIT) ? {ACCESS_LO_BK, file_addr}
                                     : {ACCESS_HI_BK, file_addr};
    end else begin
      ram_addr = {bank_select_reg, file_addr};
    end
  end

endmodule : oofd_bank_addr
`default_nettype wire

//--- rtl/oofd_table_ptr.sv
`timescale 1ns/10ps
`default_nettype none
module oofd_table_ptr
  import oofd_pkg::*;
(
  input  wire logic              core_clk,              // Core clock
  input  wire logic              arst_n,                // Async reset, low
  input  wire logic              ptr_wr,                // Datapath writes pointer
  input  wire logic [PC_W-1:0]   ptr_wr_data,           // Pointer write value
  input  wire logic              acc_go,                // Table access request
  input  wire oofd_tmode_e       acc_mode,              // Pointer mode
  input  wire logic              acc_write,             // Table write access
  input  wire logic              rd_valid,              // Program read data valid
  input  wire logic [7:0]        rd_data,               // Program read data
  input  wire logic              lat_wr,                // Datapath writes latch
  input  wire logic [7:0]        lat_wr_data,           // Latch write value
  output logic [PC_W-1:0]        program_table_pointer, // Pointer value
  output logic [7:0]             table_data_latch,      // Table latch value
  output logic                   acc_req,               // Access pulse
  output logic                   acc_is_write,          // Access direction
  output logic [PC_W-1:0]        acc_addr               // Access address
);

  logic [PC_W-1:0] ptr_q, ptr_d, addr_q, addr_d;
  logic [7:0]      lat_q, lat_d;
  logic            req_q, req_d, wr_q, wr_d;

  // Pointer mode handling and latch capture
  always_comb begin
    ptr_d  = ptr_q;
    addr_d = addr_q;
    lat_d  = lat_q;
    req_d  = 1'b0;
    wr_d   = wr_q;
    if (acc_go) begin
      req_d  = 1'b1;
      wr_d   = acc_write;
      addr_d = ptr_q;
      case (acc_mode)
        TM_KEEP:     ptr_d = ptr_q;
        TM_POST_INC: ptr_d = ptr_q + PC_W'(1);
        TM_POST_DEC: ptr_d = ptr_q - PC_W'(1);
        TM_PRE_INC: begin
          ptr_d  = ptr_q + PC_W'(1);
          addr_d = ptr_q + PC_W'(1);
        end
        default:     ptr_d = ptr_q;
      endcase
    end else if (ptr_wr) begin
      ptr_d = ptr_wr_data;
    end
    if (rd_valid) begin
      lat_d = rd_data;
    end else if (lat_wr) begin
      lat_d = lat_wr_data;
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q  <= TPTR_RST;
      addr_q <= TPTR_RST;
      lat_q  <= TLATCH_RST;
      req_q  <= 1'b0;
      wr_q   <= 1'b0;
    end else begin
      ptr_q  <= ptr_d;
      addr_q <= addr_d;
      lat_q  <= lat_d;
      req_q  <= req_d;
      wr_q   <= wr_d;
    end
  end

  assign program_table_pointer = ptr_q;
  assign table_data_latch      = lat_q;
  assign acc_req               = req_q;
  assign acc_is_write          = wr_q;
  assign acc_addr              = addr_q;

endmodule : oofd_table_ptr
`default_nettype wire

//--- rtl/oofd_field_decoder.sv
// Operation
// - access bit 0 uses access RAM ignoring bank select; 1 uses bank select.
// - three-bit field picks one bit, 0 to 7, of an 8-bit register.
// - destination bit 0 writes accumulator; 1 writes the file register.
// - file operand is 8-bit address, or 2-bit pointer select for loads.
// - two-word move takes 12-bit source address from first word.
// - two-word move takes 12-bit destination address from second word.
// - fast bit 1 saves/restores shadow registers; 0 leaves them untouched.
// - table ops support keep, post-increment, post-decrement, pre-increment.
// - 21-bit table pointer addresses program memory via 8-bit latch.
// - relative branches and relative calls use two's complement offsets; other calls, gotos direct.
// - don't-care bits never change decoding; zero is recommended.
// - indexed moves take a 7-bit source offset and either a 7-bit destination offset or a 12-bit destination address.
// - each single word is 16 bits split into opcode and operands.
// - second words carry four leading ones and alone act as no-op.
`timescale 1ns/10ps
`default_nettype none
module oofd_field_decoder
  import oofd_pkg::*;
(
  input  wire logic               core_clk,              // Core clock
  input  wire logic               arst_n,                // Async reset, low
  input  wire logic               instr_valid,           // Word present
  input  wire logic [INSTR_W-1:0] instr_word,            // Instruction word
  input  wire logic [PC_W-1:0]    instr_pc,              // Byte address of word
  input  wire logic [BANK_W-1:0]  bank_select_reg,       // Current bank
  input  wire logic               ptr_wr,                // Pointer write
  input  wire logic [PC_W-1:0]    ptr_wr_data,           // Pointer value
  input  wire logic               tbl_rd_valid,          // Read data valid
  input  wire logic [7:0]         tbl_rd_data,           // Read data
  input  wire logic               lat_wr,                // Latch write
  input  wire logic [7:0]         lat_wr_data,           // Latch value
  output logic                    dec_valid,             // Decode pulse
  output oofd_dec_s               dec,                   // Decoded fields
  output logic                    second_pending,        // Awaiting word 2
  output logic [PC_W-1:0]         program_table_pointer, // Table pointer
  output logic [7:0]              table_data_latch,      // Table latch
  output logic                    tbl_req,               // Table access pulse
  output logic                    tbl_is_write,          // Access direction
  output logic [PC_W-1:0]         tbl_addr               // Access address
);

  oofd_state_e            st_q, st_d;
  oofd_dec_s              dec_q, dec_d, pend_q, pend_d, first_dec;
  logic                   valid_q, valid_d;
  logic [RAM_ADDR_W-1:0]  bank_addr;
  logic                   tbl_go;

  // Bit number to one-hot mask
  function automatic logic [7:0] bit_onehot(input logic [2:0] n);
    logic [7:0] m;
    m = 8'h00;
    m[n] = 1'b1;
    return m;
  endfunction : bit_onehot

  // Opcodes whose operand continues in a second word
  function automatic logic wants_second(input logic [15:0] w);
    logic r;
    r = 1'b0;
    case (w[15:12])
      4'hC: begin
        r = 1'b1;
      end
      4'hE: begin
        if (w[11:9] == 3'b110) begin
          r = 1'b1;
        end else if (w[11:8] == 4'hF) begin
          r = 1'b1;
        end else if (w[11:8] == 4'hB) begin
          r = 1'b1;
        end else if (w[11:6] == 6'b111000) begin
          r = 1'b1;
        end else begin
          r = 1'b0;
        end
      end
      default: r = 1'b0;
    endcase
    return r;
  endfunction : wants_second

  // Relative target: address of the next word plus twice the signed offset
  function automatic logic [PC_W-1:0] rel_target(
    input logic [PC_W-1:0] pc,
    input logic [10:0]     ofs
  );
    logic [PC_W-1:0] step;
    step = {{(PC_W-12){ofs[10]}}, ofs, 1'b0};
    return pc + PC_STEP + step;
  endfunction : rel_target

  // First-word field split
  function automatic oofd_dec_s decode_first(
    input logic [15:0]           w,
    input logic [PC_W-1:0]       pc,
    input logic [RAM_ADDR_W-1:0] baddr
  );
    oofd_dec_s  r;
    r = '0;
    r.cls = CL_NOP;
    r.table_pointer_mode = TM_KEEP;
    // Fields set from the same bits for every format; pointer loads then replace the literal
    r.use_bank = w[8];
    r.ram_addr = baddr;
    r.literal = {4'h0, w[7:0]};
    case (w[15:12])
      // Byte, literal, table and return formats
      4'h0: begin
        if (w[11:8] >= 4'h8) begin
          r.cls = CL_LIT;
        end else if (w[11:10] != 2'b00) begin
          r.cls = CL_BYTE;
          r.dest_file = w[9];
        end else if (w[11:8] == 4'h0 && w[7:4] == 4'h0) begin
          if (w[3]) begin
            r.cls = CL_TBL;
            r.tbl_write = w[2];
            r.table_pointer_mode = oofd_tmode_e'(w[1:0]);
          end else if (w[3:1] == 3'b001) begin
            r.cls = CL_RET;
            r.fast_shadow = w[0];
          end
        end else if (w[11:9] == 3'b001) begin
          r.cls = CL_BYTE;
          r.dest_file = 1'b0;
        end else if (w[11:8] == 4'h1) begin
          r.cls = CL_LIT;
        end
      end
      // Byte operations with destination select
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
        r.cls = CL_BYTE;
        r.dest_file = w[9];
      end
      // Byte operations that always write the file register
      4'h6: begin
        r.cls = CL_BYTE;
        r.dest_file = 1'b1;
      end
      // Bit operations
      4'h7, 4'h8, 4'h9, 4'hA, 4'hB: begin
        r.cls = CL_BIT;
        r.bit_num = w[11:9];
        r.bit_mask = bit_onehot(w[11:9]);
        r.dest_file = 1'b1;
      end
      // First word of the register move
      4'hC: begin
        r.cls = CL_MOVE2;
        r.src_addr = w[11:0];
      end
      // Long relative branch and relative call
      4'hD: begin
        if (w[11]) begin
          r.cls = CL_CALL;
        end else begin
          r.cls = CL_REL;
        end
        r.rel_branch = 1'b1;
        r.target = rel_target(pc, w[10:0]);
      end
      // Short branches, calls, jumps, indexed moves and pointer loads
      4'hE: begin
        if (w[11] == 1'b0) begin
          r.cls = CL_REL;
          r.rel_branch = 1'b1;
          r.target = rel_target(pc, {{3{w[7]}}, w[7:0]});
        end else if (w[11:9] == 3'b110) begin
          r.cls = CL_CALL;
          r.fast_shadow = w[8];
        end else if (w[11:8] == 4'hF) begin
          r.cls = CL_GOTO;
        end else if (w[11:8] == 4'hB) begin
          r.cls = CL_INDEXED;
          r.src_ofs = w[6:0];
          r.dst_is_ofs = w[7];
        end else if (w[11:6] == 6'b111000) begin
          r.cls = CL_PTR_LOAD;
          r.ptr_sel = w[5:4];
          r.literal = {8'h00, w[3:0]};
        end else begin
          r.cls = CL_NOP;
        end
      end
      // Lone second words (opcode F), the only opcode left to the default
      default: r.cls = CL_NOP;
    endcase
    return r;
  endfunction : decode_first

  // Second-word completion; unused bits are ignored
  function automatic oofd_dec_s decode_second(
    input oofd_dec_s   p,
    input logic [15:0] w
  );
    oofd_dec_s r;
    r = p;
    case (p.cls)
      CL_MOVE2: r.dst_addr = w[11:0];
      // Indexed move keeps either an offset or a full address
      CL_INDEXED: begin
        if (p.dst_is_ofs) begin
          r.dst_ofs = w[6:0];
        end else begin
          r.dst_addr = w[11:0];
        end
      end
      // Direct targets are word aligned
      CL_CALL, CL_GOTO: begin
        r.target = {w[11:0], p.literal[7:0], 1'b0};
      end
      CL_PTR_LOAD: r.literal = {p.literal[3:0], w[7:0]};
      default: r = p;
    endcase
    return r;
  endfunction : decode_second

  // Bank/access address former
  oofd_bank_addr u_bank (
    .file_addr       (instr_word[7:0]),
    .access_bit      (instr_word[8]),
    .bank_select_reg (bank_select_reg),
    .ram_addr        (bank_addr)
  );

  // First-word decode, used at once or parked for the second word
  assign first_dec = decode_first(instr_word, instr_pc, bank_addr);

  // Word sequencer next state
  always_comb begin
    st_d    = st_q;
    dec_d   = dec_q;
    pend_d  = pend_q;
    valid_d = 1'b0;
    if (instr_valid) begin
      case (st_q)
        ST_FIRST: begin
          if (wants_second(instr_word)) begin
            // Park the first word until its partner arrives
            st_d   = ST_SECOND;
            pend_d = first_dec;
          end else begin
            dec_d   = first_dec;
            valid_d = 1'b1;
          end
        end
        ST_SECOND: begin
          // Whatever word comes next completes the pair
          st_d    = ST_FIRST;
          dec_d   = decode_second(pend_q, instr_word);
          valid_d = 1'b1;
        end
        default: st_d = ST_FIRST;
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= ST_FIRST;
      dec_q   <= '0;
      pend_q  <= '0;
      valid_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      dec_q   <= dec_d;
      pend_q  <= pend_d;
      valid_q <= valid_d;
    end
  end

  // Table access starts on the pulse of a decoded table instruction
  assign tbl_go = valid_q && (dec_q.cls == CL_TBL);

  // Table pointer and latch, steered by decoded table operations
  oofd_table_ptr u_tbl (
    .core_clk              (core_clk),
    .arst_n                (arst_n),
    .ptr_wr                (ptr_wr),
    .ptr_wr_data           (ptr_wr_data),
    .acc_go                (tbl_go),
    .acc_mode              (dec_q.table_pointer_mode),
    .acc_write             (dec_q.tbl_write),
    .rd_valid              (tbl_rd_valid),
    .rd_data               (tbl_rd_data),
    .lat_wr                (lat_wr),
    .lat_wr_data           (lat_wr_data),
    .program_table_pointer (program_table_pointer),
    .table_data_latch      (table_data_latch),
    .acc_req               (tbl_req),
    .acc_is_write          (tbl_is_write),
    .acc_addr              (tbl_addr)
  );

  // Outputs straight from the sequencer registers
  assign dec_valid      = valid_q;
  assign dec            = dec_q;
  assign second_pending = (st_q == ST_SECOND);

endmodule : oofd_field_decoder
`default_nettype wire

//--- verification/oofd_props.sv
`timescale 1ns/10ps
`default_nettype none
module oofd_props
  import oofd_pkg::*;
(
  input wire logic        core_clk,              // Clock
  input wire logic        arst_n,                // Reset, low
  input wire logic        instr_valid,           // Word present
  input wire logic [15:0] instr_word,            // Word
  input wire logic        tbl_rd_valid,          // Read byte valid
  input wire logic [7:0]  tbl_rd_data,           // Read byte
  input wire logic        dec_valid,             // Decode pulse
  input wire oofd_dec_s   dec,                   // Fields
  input wire logic        second_pending,        // Waiting word 2
  input wire logic [20:0] program_table_pointer, // Pointer
  input wire logic [7:0]  table_data_latch,      // Latch
  input wire logic        tbl_req,               // Access pulse
  input wire logic [20:0] tbl_addr               // Access address
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // First words that announce a second word
  function automatic logic two_w(input logic [15:0] w);
    return w[15:12] == 4'hC || (w[15:12] == 4'hE && (w[11:9] == 3'h6 ||
           w[11:8] == 4'hF || w[11:8] == 4'hB || w[11:6] == 6'h38));
  endfunction : two_w

  // Table access helpers
  logic        tbl_go;
  logic [20:0] stp_c;
  logic [20:0] pre_c;
  assign tbl_go = dec_valid && dec.cls == CL_TBL;
  assign stp_c  = (dec.table_pointer_mode == TM_KEEP) ? 21'h000000 :
                  (dec.table_pointer_mode == TM_POST_DEC) ? 21'h1FFFFF :
                  21'h000001;
  assign pre_c  = (dec.table_pointer_mode == TM_PRE_INC) ? 21'h000001 :
                  21'h000000;

  property p_single;
    instr_valid && !second_pending && !two_w(instr_word) |=> dec_valid;
  endproperty
  a_single: assert property (p_single)
    else $error("single word not decoded");
  property p_pend;
    instr_valid && !second_pending && two_w(instr_word)
      |=> second_pending && !dec_valid;
  endproperty
  a_pend: assert property (p_pend)
    else $error("first word did not wait");
  property p_second;
    instr_valid && second_pending |=> dec_valid && !second_pending;
  endproperty
  a_second: assert property (p_second)
    else $error("second word not completed");
  property p_nop;
    instr_valid && !second_pending && instr_word[15:12] == SECOND_TAG
      |=> dec_valid && dec.cls == CL_NOP;
  endproperty
  a_nop: assert property (p_nop)
    else $error("lone second word not a no-op");
  property p_treq;
    tbl_req == $past(tbl_go);
  endproperty
  a_treq: assert property (p_treq)
    else $error("table access pulse wrong");
  property p_tptr;
    tbl_go |=> program_table_pointer ==
      21'($past(program_table_pointer) + $past(stp_c)) &&
      tbl_addr == 21'($past(program_table_pointer) + $past(pre_c));
  endproperty
  a_tptr: assert property (p_tptr)
    else $error("table pointer mode wrong");
  property p_latch;
    tbl_rd_valid |=> table_data_latch == $past(tbl_rd_data);
  endproperty
  a_latch: assert property (p_latch)
    else $error("table latch not loaded");
  property p_access;
    dec_valid && dec.cls == CL_BYTE && !dec.use_bank |-> dec.ram_addr[11:8]
      == ((dec.ram_addr[7:0] < ACCESS_SPLIT) ? ACCESS_LO_BK : ACCESS_HI_BK);
  endproperty
  a_access: assert property (p_access)
    else $error("access bank address wrong");
  property p_mask;
    dec_valid && dec.cls == CL_BIT |-> dec.bit_mask == 8'h01 << dec.bit_num;
  endproperty
  a_mask: assert property (p_mask)
    else $error("bit mask wrong");
endmodule : oofd_props

bind oofd_field_decoder oofd_props oofd_props_inst (.core_clk, .arst_n,
  .instr_valid, .instr_word, .tbl_rd_valid, .tbl_rd_data, .dec_valid, .dec,
  .second_pending, .program_table_pointer, .table_data_latch, .tbl_req,
  .tbl_addr);
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import oofd_pkg::*;
();
  logic        core_clk = 1'b0;
  logic        arst_n, instr_valid, ptr_wr, tbl_rd_valid, lat_wr;
  logic [15:0] instr_word;
  logic [20:0] instr_pc, ptr_wr_data, program_table_pointer, tbl_addr, pc;
  logic [3:0]  bank_select_reg;
  logic [7:0]  tbl_rd_data, lat_wr_data, table_data_latch, k, r;
  logic        dec_valid, second_pending, tbl_req, tbl_is_write;
  oofd_dec_s   dec;
  logic [15:0] w;
  logic [11:0] x;
  logic [10:0] n;
  logic [6:0]  z;
  int          n_errors = 0;
  int          total_checks = 0;
  int          i;

  // Clock
  always #4 core_clk = ~core_clk;

  oofd_field_decoder oofd_field_decoder_inst (.core_clk, .arst_n,
    .instr_valid, .instr_word, .instr_pc, .bank_select_reg, .ptr_wr,
    .ptr_wr_data, .tbl_rd_valid, .tbl_rd_data, .lat_wr, .lat_wr_data,
    .dec_valid, .dec, .second_pending, .program_table_pointer,
    .table_data_latch, .tbl_req, .tbl_is_write, .tbl_addr);

  // Expected full data address
  function automatic logic [11:0] exp_ram(input logic [7:0] f,
                                          input logic a, input logic [3:0] b);
    if (a)
      return {b, f};
    return {(f < ACCESS_SPLIT) ? ACCESS_LO_BK : ACCESS_HI_BK, f};
  endfunction : exp_ram

  // Expected pointer after an access
  function automatic logic [20:0] exp_ptr(input logic [1:0] m,
                                          input logic [20:0] p0);
    if (m == 2'h2)
      return p0 - 21'h000001;
    return (m == 2'h0) ? p0 : p0 + 21'h000001;
  endfunction : exp_ptr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic issue(input logic [15:0] wd, input logic [20:0] a);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word  <= wd;
    instr_pc    <= a;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
  endtask : issue

  task automatic issue2(input logic [15:0] w1, input logic [15:0] w2);
    issue(w1, 21'h000000);
    chk(second_pending, 1'b1);
    issue(w2, 21'h000000);
    chk(dec_valid, 1'b1);
    chk(second_pending, 1'b0);
  endtask : issue2

  task automatic tbl(input logic [2:0] m, input logic [20:0] p0);
    @(posedge core_clk);
    ptr_wr      <= 1'b1;
    ptr_wr_data <= p0;
    @(posedge core_clk);
    ptr_wr <= 1'b0;
    issue({12'h000, 1'b1, m}, 21'h000000);
    chk(dec.cls, CL_TBL);
    chk(dec.table_pointer_mode, m[1:0]);
    @(posedge core_clk);
    #1;
    chk(tbl_req, 1'b1);
    chk(tbl_is_write, m[2]);
    chk(tbl_addr, 21'(p0 + 21'(m[1:0] == 2'h3)));
    chk(program_table_pointer, exp_ptr(m[1:0], p0));
  endtask : tbl

  task automatic stop_test;
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // Watchdog
  initial begin
    repeat (6000) @(posedge core_clk);
    n_errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    void'($urandom(74707));
    {arst_n, instr_valid, ptr_wr, tbl_rd_valid, lat_wr} = 5'h00;
    {instr_word, instr_pc, ptr_wr_data} = '0;
    {bank_select_reg, tbl_rd_data, lat_wr_data} = '0;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    // Byte and bit operations, access split corners first
    for (i = 0; i < 64; i++) begin
      @(posedge core_clk);
      bank_select_reg <= 4'($urandom);
      w = i[0] ? {4'($urandom_range(11, 8)), 12'($urandom)} :
                 {4'($urandom_range(5, 1)), 12'($urandom)};
      if (i < 4)
        w[8:0] = {1'b0, 8'h5F + 8'(i[2:1])};
      issue(w, 21'h000000);
      chk(dec_valid, 1'b1);
      chk(dec.use_bank, w[8]);
      chk(dec.ram_addr, exp_ram(w[7:0], w[8], bank_select_reg));
      if (i[0]) begin
        chk(dec.cls, CL_BIT);
        chk(dec.bit_num, w[11:9]);
        chk(dec.bit_mask, 8'h01 << w[11:9]);
      end else begin
        chk(dec.cls, CL_BYTE);
        chk(dec.dest_file, w[9]);
      end
    end
    // Two-word forms, lone second words and relative branches
    for (i = 0; i < 8; i++) begin
      x = 12'($urandom);
      k = 8'($urandom);
      z = 7'($urandom);
      issue2({4'hC, k, z[3:0]}, {4'hF, x});
      chk(dec.cls, CL_MOVE2);
      chk(dec.src_addr, {k, z[3:0]});
      chk(dec.dst_addr, x);
      issue2({7'h76, i[0], k}, {4'hF, x});
      chk(dec.cls, CL_CALL);
      chk(dec.fast_shadow, i[0]);
      chk(dec.target, {x, k, 1'b0});
      issue2({8'hEF, k}, {4'hF, x});
      chk(dec.cls, CL_GOTO);
      chk(dec.target, {x, k, 1'b0});
      issue2({10'h3B8, z[5:0]}, {8'hF0, k});
      chk(dec.cls, CL_PTR_LOAD);
      chk(dec.ptr_sel, z[5:4]);
      chk(dec.literal, {z[3:0], k});
      issue2({9'h1D6, z}, {4'hF, x});
      chk(dec.src_ofs, z);
      chk(dec.dst_is_ofs, 1'b0);
      chk(dec.dst_addr, x);
      issue2({9'h1D7, k[6:0]}, {4'hF, x[11:7], z});
      chk(dec.cls, CL_INDEXED);
      chk(dec.dst_is_ofs, 1'b1);
      chk(dec.dst_ofs, z);
      issue({4'hF, x}, 21'h000000);
      chk(dec_valid, 1'b1);
      chk(dec.cls, CL_NOP);
      n  = (i == 0) ? 11'h400 : 11'($urandom);
      pc = {20'($urandom), 1'b0};
      issue({5'h1A, n}, pc);
      chk(dec.rel_branch, 1'b1);
      chk(dec.target, 21'(pc + PC_STEP + {{9{n[10]}}, n, 1'b0}));
      issue({5'h1B, n}, pc);
      chk(dec.cls, CL_CALL);
      chk(dec.target, 21'(pc + PC_STEP + {{9{n[10]}}, n, 1'b0}));
      issue({5'h1C, n[10:8], k}, pc);
      chk(dec.cls, CL_REL);
      chk(dec.target, 21'(pc + PC_STEP + {{12{k[7]}}, k, 1'b0}));
      issue({15'h0001, i[0]}, 21'h000000);
      chk(dec.cls, CL_RET);
      chk(dec.fast_shadow, i[0]);
    end
    // Every table mode and direction, with wrap corners
    for (i = 0; i < 16; i++)
      tbl(3'(i), (i == 2) ? 21'h000000 :
                 (i[1:0] == 2'h3) ? 21'h1FFFFF : 21'($urandom));
    // Table latch loads, read data beats a datapath write
    k = 8'($urandom);
    r = 8'($urandom);
    @(posedge core_clk);
    lat_wr      <= 1'b1;
    lat_wr_data <= k;
    @(posedge core_clk);
    tbl_rd_valid <= 1'b1;
    tbl_rd_data  <= r;
    lat_wr_data  <= ~r;
    #1;
    chk(table_data_latch, k);
    @(posedge core_clk);
    tbl_rd_valid <= 1'b0;
    lat_wr       <= 1'b0;
    #1;
    chk(table_data_latch, r);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
